// ### rtl/as_link_pkg.sv
package as_link_pkg;
  // ==========================================================
  // Link framing
  localparam int        CMD_W      = 8;
  localparam int        ADDR_W     = 24;
  localparam int        FRAME_W    = CMD_W + ADDR_W;
  localparam logic [7:0] READ_CMD  = 8'h03;
  localparam logic [23:0] START_ADDR = 24'h000000;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // ==========================================================
  // Default sizes and counts; sizes in bytes or bits, counts in system clock cycles
  localparam int        MEM_BYTES    = 256;
  localparam int        CFG_BYTES    = 16;
  localparam int        HALF_DIV     = 4;
  localparam int        DONE_WAIT    = 16;
  localparam int        INIT_CYCLES  = 8;
  localparam int        STATUS_PULSE = 4;
  localparam int        SYNC_W       = 4;
  // Sync vector bit positions
  localparam int        SY_REQ  = 0;
  localparam int        SY_AS   = 1;
  localparam int        SY_BIT  = 2;
  localparam int        SY_DONE = 3;
  // ==========================================================
  // Flash receive phases and master states
  typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA, PH_IGNORE} flash_phase_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEND, ST_READ, ST_RELEASE, ST_INIT, ST_USER, ST_RESTART
  } master_state_t;
endpackage

// ### rtl/as_link_if.sv
`timescale 1ns/1ps
// ==========================================================
// Four-wire configuration link plus done and status lines
interface as_link_if;
  logic serial_clock;
  logic flash_select_n;
  logic master_serial_out;
  logic flash_serial_in;
  logic flash_data;
  logic flash_data_oe;
  logic master_bit_in;
  logic complete_oe;
  logic config_complete;
  logic config_state_n;
  logic done_hold;       // Followers still holding done low
  // Wire resolution: pull-ups on data and done lines
  assign flash_serial_in = master_serial_out;
  assign master_bit_in   = flash_data_oe ? flash_data : 1'b1;
  assign config_complete = !complete_oe && !done_hold;
  modport master (
    output serial_clock, flash_select_n, master_serial_out,
    output complete_oe, config_state_n,
    input  master_bit_in, config_complete
  );
  modport flash (
    input  serial_clock, flash_select_n, flash_serial_in,
    output flash_data, flash_data_oe
  );
endinterface

// ### rtl/flash_byte_array.sv
`timescale 1ns/1ps
// ==========================================================
// Byte array: written from system clock, read combinationally
module flash_byte_array
  import as_link_pkg::*;
#(
  parameter int BYTES = MEM_BYTES,
  parameter int AW    = $clog2(MEM_BYTES)
) (
  input  wire logic          clk_in,
  input  wire logic          erase_in,
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [7:0]    wr_data_in,
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [7:0]    rd_data_out
);
  logic [7:0] mem [BYTES];

  // As delivered every bit is one
  initial begin
    for (int i = 0; i < BYTES; i++) begin
      mem[i] = ERASED_BYTE;
    end
  end

  // Erase wins over a write in the same cycle; plain always because
  // the power-up image above also writes the array
  always @(posedge clk_in) begin
    if (erase_in) begin
      for (int i = 0; i < BYTES; i++) begin
        mem[i] <= ERASED_BYTE;
      end
    end else if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  assign rd_data_out = mem[rd_addr_in];
endmodule

// ### rtl/serial_flash_end.sv
`timescale 1ns/1ps
// ==========================================================
// Flash end: link side runs on the master's serial clock, programming port on the system clock
module serial_flash_end
  import as_link_pkg::*;
#(
  parameter int BYTES = MEM_BYTES
) (
  as_link_if.flash         link,
  input  wire logic        SYS_CLK_IN,
  input  wire logic        ARST_N_IN,
  input  wire logic        PROG_ERASE_IN,
  input  wire logic        PROG_WE_IN,
  input  wire logic [$clog2(BYTES)-1:0] PROG_ADDR_IN,
  input  wire logic [7:0]  PROG_BYTE_IN,
  output logic             PROG_ACK_OUT
);
  localparam int AW = $clog2(BYTES);

  initial begin
    if (BYTES < 2 || (1 << AW) != BYTES) $error("BYTES must be a power of two");
  end

  flash_phase_t   phase;
  logic [7:0]     cnt;
  logic [FRAME_W-1:0] rx_sr;
  logic [AW-1:0]  rd_ptr;
  logic [2:0]     bit_idx;
  logic           started;
  logic [7:0]     rd_byte;
  wire  [AW-1:0]  cur_ptr = started ? rd_ptr : rx_sr[AW-1:0];
  wire  [2:0]     cur_idx = started ? bit_idx : 3'h7;
  wire  [FRAME_W-1:0] rx_next = {rx_sr[FRAME_W-2:0], link.flash_serial_in};

  flash_byte_array #(.BYTES(BYTES), .AW(AW)) u_array (
    .clk_in      (SYS_CLK_IN),
    .erase_in    (PROG_ERASE_IN),
    .wr_en_in    (PROG_WE_IN),
    .wr_addr_in  (PROG_ADDR_IN),
    .wr_data_in  (PROG_BYTE_IN),
    .rd_addr_in  (cur_ptr),
    .rd_data_out (rd_byte)
  );

  // ==========================================================
  // Programming acknowledge; host must not program mid-frame
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      PROG_ACK_OUT <= 1'b0;
    end else begin
      PROG_ACK_OUT <= PROG_WE_IN | PROG_ERASE_IN;
    end
  end

  // ==========================================================
  // Rising edges shift instruction then address; select high resets
  always_ff @(posedge link.serial_clock or posedge link.flash_select_n) begin
    if (link.flash_select_n) begin
      phase <= PH_CMD;
      cnt   <= 8'h00;
      rx_sr <= '0;
    end else begin
      rx_sr <= rx_next;
      case (phase)
        PH_CMD: begin
          cnt <= cnt + 8'h01;
          if (cnt == 8'(CMD_W - 1)) begin
            cnt   <= 8'h00;
            phase <= (rx_next[CMD_W-1:0] == READ_CMD) ? PH_ADDR : PH_IGNORE;
          end
        end
        PH_ADDR: begin
          cnt <= cnt + 8'h01;
          if (cnt == 8'(ADDR_W - 1)) begin
            phase <= PH_DATA;
          end
        end
        default: begin
          phase <= phase; // Unknown instructions ignored to deselect
        end
      endcase
    end
  end

  // ==========================================================
  // Falling edges launch data, MSB first, address wraps at array end
  always_ff @(negedge link.serial_clock or posedge link.flash_select_n) begin
    if (link.flash_select_n) begin
      link.flash_data    <= 1'b1;
      link.flash_data_oe <= 1'b0;
      rd_ptr             <= '0;
      bit_idx            <= 3'h7;
      started            <= 1'b0;
    end else if (phase == PH_DATA) begin
      link.flash_data    <= rd_byte[cur_idx];
      link.flash_data_oe <= 1'b1;
      started            <= 1'b1;
      bit_idx            <= cur_idx - 3'h1;
      rd_ptr             <= (cur_idx == 3'h0) ? cur_ptr + AW'(1) : cur_ptr;
    end
  end
endmodule

// ### rtl/config_master.sv
`timescale 1ns/1ps
module config_master
  import as_link_pkg::*;
#(
  parameter int HALF  = HALF_DIV,
  parameter int BYTES = CFG_BYTES,
  parameter int DWAIT = DONE_WAIT,
  parameter int INITC = INIT_CYCLES,
  parameter int PULSE = STATUS_PULSE
) (
  as_link_if.master        link,
  input  wire logic        SYS_CLK_IN,
  input  wire logic        ARST_N_IN,
  input  wire logic        CONFIG_REQUEST_N_IN,
  input  wire logic        ACTIVE_SCHEME_IN,
  output logic [7:0]       CFG_BYTE_OUT,
  output logic             CFG_VALID_OUT,
  output logic             USER_MODE_OUT
);
  localparam int BITS = BYTES * 8;

  // ==========================================================
  // Elaboration checks
  initial begin
    if (HALF < 4 || HALF > 255) $error("HALF must be 4..255 for the data sync");
    if (BYTES < 1 || BITS > 65535) $error("BYTES out of range");
    if (DWAIT < 1 || DWAIT > 65535) $error("DWAIT out of range");
    if (INITC < 1 || INITC > 65535) $error("INITC out of range");
    if (PULSE < 1 || PULSE > 65535) $error("PULSE out of range");
  end

  master_state_t    state;
  logic [7:0]       half_cnt;
  logic             sck;
  logic [FRAME_W-1:0] tx_sr;
  logic [7:0]       rx_sr;
  logic [15:0]      cnt;
  logic [15:0]      wait_cnt;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;

  // ==========================================================
  // Pin inputs through two flops each
  wire [SYNC_W-1:0] pins_raw = {
    link.config_complete, link.master_bit_in, ACTIVE_SCHEME_IN, CONFIG_REQUEST_N_IN
  };

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
    end
  end

  // Request released and active scheme strapped
  wire req_ok    = sync2[SY_REQ] && sync2[SY_AS];
  wire bit_s     = sync2[SY_BIT];
  wire done_s    = sync2[SY_DONE];

  // ==========================================================
  // Serial clock divider; runs only while a frame is open
  wire sck_run   = (state == ST_SEND) || (state == ST_READ);
  wire tick      = sck_run && (half_cnt == 8'(HALF - 1));
  wire fall_tick = tick && sck;
  wire last_send = (cnt == 16'(FRAME_W - 1));
  wire last_bit  = (cnt == 16'(BITS - 1));
  wire [7:0] rx_next = {rx_sr[6:0], bit_s};

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      half_cnt <= 8'h00;
      sck      <= 1'b0;
    end else if (!sck_run) begin
      half_cnt <= 8'h00;
      sck      <= 1'b0;
    end else if (tick) begin
      half_cnt <= 8'h00;
      sck      <= !sck;
    end else begin
      half_cnt <= half_cnt + 8'h01;
    end
  end

  // Clock pin straight from its flop
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      link.serial_clock <= 1'b0;
    end else begin
      // Request drop parks the clock with select, so a cut frame never shows a live clock
      link.serial_clock <= (sck_run && req_ok) ? (tick ? !sck : sck) : 1'b0;
    end
  end

  // ==========================================================
  // Configuration sequence
  // Done line is held low until the read ends, so a high done
  // during the frame means another driver or a short: restart.
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state                  <= ST_IDLE;
      tx_sr                  <= '0;
      rx_sr                  <= 8'h00;
      cnt                    <= 16'h0000;
      wait_cnt               <= 16'h0000;
      link.flash_select_n    <= 1'b1;
      link.master_serial_out <= 1'b0;
      link.complete_oe       <= 1'b1;
      link.config_state_n    <= 1'b1;
      CFG_BYTE_OUT           <= 8'h00;
      CFG_VALID_OUT          <= 1'b0;
      USER_MODE_OUT          <= 1'b0;
    end else begin
      CFG_VALID_OUT <= 1'b0;
      if (!req_ok && state != ST_RESTART) begin
        state                  <= ST_IDLE;
        link.flash_select_n    <= 1'b1;
        link.master_serial_out <= 1'b0;
        link.complete_oe       <= 1'b1;
        USER_MODE_OUT          <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            state                  <= ST_SEND;
            link.flash_select_n    <= 1'b0;
            link.master_serial_out <= READ_CMD[7];
            tx_sr                  <= {READ_CMD, START_ADDR} << 1;
            cnt                    <= 16'h0000;
          end
          ST_SEND: begin
            if (done_s) begin
              state <= ST_RESTART;
              wait_cnt <= 16'h0000;
            end else if (fall_tick) begin
              if (last_send) begin
                state <= ST_READ;
                cnt   <= 16'h0000;
              end else begin
                cnt                    <= cnt + 16'h0001;
                link.master_serial_out <= tx_sr[FRAME_W-1];
                tx_sr                  <= tx_sr << 1;
              end
            end
          end
          ST_READ: begin
            if (done_s) begin
              state    <= ST_RESTART;
              wait_cnt <= 16'h0000;
            end else if (fall_tick) begin
              rx_sr <= rx_next;
              cnt   <= cnt + 16'h0001;
              if (cnt[2:0] == 3'h7) begin
                CFG_BYTE_OUT  <= rx_next;
                CFG_VALID_OUT <= 1'b1;
              end
              if (last_bit) begin
                state               <= ST_RELEASE;
                link.flash_select_n <= 1'b1;
                link.complete_oe    <= 1'b0;
                wait_cnt            <= 16'h0000;
              end
            end
          end
          ST_RELEASE: begin
            wait_cnt <= wait_cnt + 16'h0001;
            if (done_s) begin
              state    <= ST_INIT;
              wait_cnt <= 16'h0000;
            end else if (wait_cnt == 16'(DWAIT - 1)) begin
              state            <= ST_RESTART;
              link.complete_oe <= 1'b1;
              wait_cnt         <= 16'h0000;
            end
          end
          ST_INIT: begin
            wait_cnt <= wait_cnt + 16'h0001;
            if (!done_s) begin
              state            <= ST_RESTART;
              link.complete_oe <= 1'b1;
              wait_cnt         <= 16'h0000;
            end else if (wait_cnt == 16'(INITC - 1)) begin
              state         <= ST_USER;
              USER_MODE_OUT <= 1'b1;
            end
          end
          ST_USER: begin
            state <= ST_USER; // Leaves only when the request or the active scheme drops
          end
          default: begin // ST_RESTART
            link.config_state_n    <= 1'b0;
            link.flash_select_n    <= 1'b1;
            link.master_serial_out <= 1'b0;
            link.complete_oe       <= 1'b1;
            USER_MODE_OUT          <= 1'b0;
            wait_cnt               <= wait_cnt + 16'h0001;
            // First pass only starts the pulse, so count to PULSE for full length
            if (wait_cnt == 16'(PULSE)) begin
              link.config_state_n <= 1'b1;
              state               <= ST_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule

// ### test/link_chk.sv
`timescale 1ns/1ps
// ==========================================================
// Link checker: watches the wires between master and flash
module link_chk
  import as_link_pkg::*;
#(
  parameter int BYTES = CFG_BYTES
) (
  input wire logic SYS_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic serial_clock,
  input wire logic flash_select_n,
  input wire logic master_serial_out,
  input wire logic flash_data,
  input wire logic flash_data_oe,
  input wire logic complete_oe,
  input wire logic config_complete,
  input wire logic config_state_n
);
  localparam int FULL = FRAME_W + BYTES * 8;
  logic        sck_prev;
  logic [15:0] rise_cnt;
  logic [31:0] frame_sh;
  wire         sck_rise      = serial_clock && !sck_prev;
  wire  [15:0] next_rise_cnt = flash_select_n ? 16'h0000 : rise_cnt + {15'h0000, sck_rise};
  wire  [31:0] next_frame_sh = sck_rise ? {frame_sh[30:0], master_serial_out} : frame_sh;
  // Rise counter per frame; cleared while deselected so frames never merge
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sck_prev <= 1'b0;
      rise_cnt <= 16'h0000;
      frame_sh <= 32'h00000000;
    end else begin
      sck_prev <= serial_clock;
      rise_cnt <= next_rise_cnt;
      frame_sh <= next_frame_sh;
    end
  end
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // ==========================================================
  // Assertions
  a_clock_still_idle: assert property (flash_select_n |-> !serial_clock)
    else $error("serial clock moves while flash is deselected");
  a_clock_high_phase: assert property (
    $rose(serial_clock) |-> serial_clock[*4] ##1 !serial_clock)
    else $error("serial clock high phase is not four cycles");
  a_clock_low_phase: assert property ($fell(serial_clock) |-> !serial_clock[*4])
    else $error("serial clock low phase shorter than four cycles");
  a_frame_header_read: assert property (
    rise_cnt == FRAME_W |-> frame_sh == {READ_CMD, START_ADDR})
    else $error("instruction and address bits wrong");
  a_data_after_addr: assert property ($rose(flash_data_oe) |-> rise_cnt == FRAME_W)
    else $error("flash data starts at wrong bit count");
  a_launch_on_fall: assert property (
    flash_data_oe && $past(flash_data_oe) && $changed(flash_data) |-> $fell(serial_clock))
    else $error("flash data changed off a falling edge");
  a_data_needs_select: assert property (flash_data_oe |-> !flash_select_n)
    else $error("flash drives data while deselected");
  a_select_held_frame: assert property ($rose(flash_select_n) |-> rise_cnt == FULL)
    else $error("select raised before whole frame");
  a_done_release_end: assert property ($rose(flash_select_n) |-> !complete_oe)
    else $error("done line not released at frame end");
  a_done_low_frame: assert property (!flash_select_n |-> complete_oe)
    else $error("done line not driven low during frame");
  a_status_pulse_len: assert property (
    $fell(config_state_n) |-> !config_state_n[*4] ##1 config_state_n)
    else $error("status pulse is not four cycles");
  c_frame_start: cover property ($fell(flash_select_n));
  c_data_launch: cover property ($rose(flash_data_oe));
  c_done_high: cover property ($rose(config_complete));
  c_status_pulse: cover property ($fell(config_state_n));
endmodule

// ### test/active_serial_config_link_test.sv
`timescale 1ns/1ps
// ==========================================================
// Both ends joined; bench drives the user and programming sides
module active_serial_config_link_test
  import as_link_pkg::*;
;
  localparam int CEILING = 20000;
  logic       sys_clk;
  logic       arst_n    = 1'b0;
  logic       req_n     = 1'b0;
  logic       scheme    = 1'b1;
  logic       hold      = 1'b0;
  logic       erase     = 1'b0;
  logic       we        = 1'b0;
  logic [7:0] addr      = 8'h00;
  logic [7:0] wdata     = 8'h00;
  logic       ack;
  logic [7:0] cfg_byte;
  logic       cfg_valid;
  logic       user_mode;
  int         errors          = 0;
  int         samples_checked = 0;
  int         cycles          = 0;
  int         i;
  as_link_if link ();
  // Follower model: may keep the done line low after release
  assign link.done_hold = hold;
  config_master config_master_inst (
    .link                (link),
    .SYS_CLK_IN          (sys_clk),
    .ARST_N_IN           (arst_n),
    .CONFIG_REQUEST_N_IN (req_n),
    .ACTIVE_SCHEME_IN    (scheme),
    .CFG_BYTE_OUT        (cfg_byte),
    .CFG_VALID_OUT       (cfg_valid),
    .USER_MODE_OUT       (user_mode)
  );
  serial_flash_end #(.BYTES(MEM_BYTES)) serial_flash_end_inst (
    .link          (link),
    .SYS_CLK_IN    (sys_clk),
    .ARST_N_IN     (arst_n),
    .PROG_ERASE_IN (erase),
    .PROG_WE_IN    (we),
    .PROG_ADDR_IN  (addr),
    .PROG_BYTE_IN  (wdata),
    .PROG_ACK_OUT  (ack)
  );
  link_chk #(.BYTES(CFG_BYTES)) link_chk_inst (
    .SYS_CLK_IN        (sys_clk),
    .ARST_N_IN         (arst_n),
    .serial_clock      (link.serial_clock),
    .flash_select_n    (link.flash_select_n),
    .master_serial_out (link.master_serial_out),
    .flash_data        (link.flash_data),
    .flash_data_oe     (link.flash_data_oe),
    .complete_oe       (link.complete_oe),
    .config_complete   (link.config_complete),
    .config_state_n    (link.config_state_n)
  );
  // ==========================================================
  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == CEILING) begin
      errors++;
      print_verdict();
    end
  end
  // ==========================================================
  // Helpers
  function automatic logic [7:0] pattern(input int k);
    return 8'h3C + 8'(k) * 8'h1D;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One byte through the programming port; ack follows a cycle later
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    we    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge sys_clk);
    we <= 1'b0;
    #1;
    check({7'h00, ack}, 8'h01);
  endtask
  // Request pulsed low: aborts user mode, then a new frame may start
  task automatic restart_request();
    @(posedge sys_clk);
    req_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check({7'h00, user_mode}, 8'h00);
    check({7'h00, link.config_complete}, 8'h00);
    req_n <= 1'b1;
  endtask
  // Collects every configuration byte, then waits for user mode
  task automatic run_frame(input logic erased);
    int n;
    for (int k = 0; k < CFG_BYTES; k++) begin
      @(posedge sys_clk);
      for (n = 0; n < 1000 && cfg_valid !== 1'b1; n++)
        @(posedge sys_clk);
      check({7'h00, cfg_valid}, 8'h01);
      check(cfg_byte, erased ? ERASED_BYTE : pattern(k));
    end
    check({7'h00, user_mode}, 8'h00);
    for (n = 0; n < 100 && user_mode !== 1'b1; n++)
      @(posedge sys_clk);
    check({7'h00, user_mode}, 8'h01);
    check({7'h00, link.config_complete}, 8'h01);
    check({7'h00, link.flash_select_n}, 8'h01);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    // Request held low: no frame may start
    for (i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      check({7'h00, link.flash_select_n}, 8'h01);
    end
    req_n <= 1'b1;
    run_frame(1'b1);
    for (i = 0; i < CFG_BYTES; i++)
      write_byte(8'(i), pattern(i));
    restart_request();
    run_frame(1'b0);
    // Erase brings back the all-ones image
    @(posedge sys_clk);
    erase <= 1'b1;
    @(posedge sys_clk);
    erase <= 1'b0;
    #1;
    check({7'h00, ack}, 8'h01);
    restart_request();
    run_frame(1'b1);
    // Followers keep done low: release times out, status pulses, frame repeats
    @(posedge sys_clk);
    hold <= 1'b1;
    restart_request();
    for (i = 0; i < 2000 && link.config_state_n !== 1'b0; i++)
      @(posedge sys_clk);
    check({7'h00, link.config_state_n}, 8'h00);
    for (i = 0; i < 8 && link.config_state_n !== 1'b1; i++)
      @(posedge sys_clk);
    check(8'(i), 8'(STATUS_PULSE));
    hold <= 1'b0;
    run_frame(1'b1);
    // Follower scheme: link stays idle and done held low
    @(posedge sys_clk);
    scheme <= 1'b0;
    restart_request();
    for (i = 0; i < 300; i++) begin
      @(posedge sys_clk);
      check({7'h00, link.flash_select_n}, 8'h01);
    end
    check({7'h00, link.config_complete}, 8'h00);
    print_verdict();
  end
endmodule
